// ===== common/phy_an_pkg.sv
// Constants and carriers for the auto-negotiation register bank.
// Assumes a 32-bit AHB-Lite bus, one register per aligned word.
package phy_an_pkg;
    // Register indexes; byte address is four times the index
    localparam logic [5:0] IDX_CTRL = 6'h00;
    localparam logic [5:0] IDX_STAT = 6'h01;
    localparam logic [5:0] IDX_PARTNER = 6'h05;
    localparam logic [5:0] IDX_EXPAN = 6'h06;
    localparam logic [5:0] IDX_NP_TX = 6'h07;
    localparam logic [5:0] IDX_NP_RX = 6'h08;
    localparam logic [5:0] IDX_GIG = 6'h09;
    localparam int IDX_LSB = 2;

    // Bit positions
    localparam int CTRL_RESTART = 9;
    localparam int STAT_DONE = 5;
    localparam int PA_NEXT_PAGE = 15;
    localparam int PA_ACK = 14;
    localparam int PA_FAULT = 13;
    localparam int PA_RSVD = 12;
    localparam int PA_ASYM = 11;
    localparam int EXP_PAR_FAULT = 4;
    localparam int EXP_PEER_NP = 3;
    localparam int EXP_NP_ABLE = 2;
    localparam int EXP_PAGE_RX = 1;
    localparam int EXP_PEER_AN = 0;
    localparam int NP_MORE = 15;
    localparam int NP_RSVD = 14;
    localparam int NP_MSG = 13;
    localparam int NP_COMPLY = 12;
    localparam int NP_TOGGLE = 11;

    // Values after reset
    localparam logic [15:0] PA_RST = 16'h0000;
    localparam logic [15:0] NP_TX_RST = 16'h2001;
    localparam logic [15:0] NP_RX_RST = 16'h0000;
    localparam logic [7:0] GIG_RST = 8'h03;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;

    typedef enum logic [2:0] {
        TM_NORMAL = 3'h0,
        TM_WAVEFORM = 3'h1,
        TM_MASTER_JITTER = 3'h2,
        TM_SLAVE_JITTER = 3'h3,
        TM_DISTORTION = 3'h4
    } test_mode_e;

    // Gigabit control word, bits 15 down to 8
    typedef struct packed {
        logic [2:0] test_mode;
        logic ms_manual;
        logic ms_master;
        logic multi_port;
        logic adv_full;
        logic adv_half;
    } gig_ctrl_s;

    // Link code word taken from the partner
    typedef struct packed {
        logic valid;
        logic base_page;
        logic [15:0] link_code_word;
    } lcw_rx_s;
endpackage : phy_an_pkg

// ===== hdl/phy_an_regs.sv
// Auto-negotiation partner, expansion, next page and gigabit control bank.
// Assumes an AHB-Lite master, word transfers only, and a negotiation
// engine that delivers link code words and events synchronous to hclk.
//
// Summary of operation
// (RQ1) Partner ability bit 15 shows partner next page capability, 0 at reset.
// (RQ2) Partner ability bit 14 reads 1 once any link code word arrived.
// (RQ3) Partner ability bit 13 mirrors the remote fault of the base page.
// (RQ4) Bit 11 asymmetric pause is writable; bit 10 symmetric pause is read-only.
// (RQ5) Bit 9 shows partner T4 ability only; local side never does T4.
// (RQ6) Bits 8..5 hold partner 100 full/half and 10 full/half abilities.
// (RQ7) Five-bit selector holds received selector, zero after reset.
// (RQ8) Expansion bit 4 latches parallel detection fault until read.
// (RQ9) Expansion bit 1 latches when a new page is received.
// (RQ10) Expansion bit 3 partner next page; bit 0 partner negotiation ability.
// (RQ11) Expansion bit 2 always reads 1: local next page able.
// (RQ12) Software writes next page more, message and comply bits.
// (RQ13) Transmit toggle bit is opposite of previous sent word's toggle.
// (RQ14) Transmit eleven-bit code field is writable, resets to one.
// (RQ15) Received next page register is read-only, all zero at reset.
// (RQ16) Test mode codes 1..4 select the four transmitter tests.
// (RQ17) Test mode 0 is normal and reset value; 5..7 reserved.
// (RQ18) Manual enable bit 12 lets bit 11 force master or slave.
// (RQ19) Bit 10 gives port type: single or multi port.
// (RQ20) Bits 9 and 8 advertise gigabit full and half duplex, reset 1.
// (RQ21) Writing restart bit 9 restarts negotiation; bit clears itself.
// (RQ22) Status bit 5 reads 1 while an_complete is high, 0 again when it drops.
// (RQ23) Latched expansion flags clear on read unless the event recurs.
module phy_an_regs
    import phy_an_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire lcw_rx_s lcw_rx,
    input wire logic tx_page_sent,
    input wire logic partner_an_able,
    input wire logic parallel_fault,
    input wire logic an_complete,
    output logic an_restart,
    output logic [15:0] np_tx_word,
    output gig_ctrl_s gig_cfg,
    output test_mode_e test_mode,
    output logic role_forced,
    output logic role_master
);
    logic [15:0] pa_reg;
    logic [15:0] np_rx_reg;
    logic [15:0] np_tx_reg;
    logic exp_pf_reg;
    logic exp_pr_reg;
    logic exp_pnp_reg;
    logic exp_ana_reg;
    logic done_reg;
    logic wr_pend_reg;
    logic rd_pend_reg;
    logic [5:0] wr_idx_reg;
    logic [5:0] rd_idx_reg;
    logic hreadyout_reg;
    logic [31:0] hrdata_reg;
    logic restart_reg;
    gig_ctrl_s gig_reg;
    test_mode_e tm_reg;
    logic forced_reg;
    logic master_reg;
    logic accept;
    logic wr_now;
    logic rd_now;
    logic exp_clear;
    logic base_rx;
    logic next_rx;
    logic [15:0] rd_word;

    assign hreadyout = hreadyout_reg;
    assign hresp = 1'b0;
    assign hrdata = hrdata_reg;
    assign an_restart = restart_reg;
    assign np_tx_word = np_tx_reg;
    assign gig_cfg = gig_reg;
    assign test_mode = tm_reg;
    assign role_forced = forced_reg;
    assign role_master = master_reg;

    assign accept = hsel && htrans[1] && hready;
    assign wr_now = wr_pend_reg;
    assign rd_now = rd_pend_reg;
    assign exp_clear = rd_now && (rd_idx_reg == IDX_EXPAN);
    assign base_rx = lcw_rx.valid && lcw_rx.base_page;
    assign next_rx = lcw_rx.valid && !lcw_rx.base_page;

    function automatic logic wr_hit(input logic [5:0] idx);
        wr_hit = wr_now && (wr_idx_reg == idx);
    endfunction : wr_hit

    // Bus phases: writes complete with no wait, reads take one wait
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            wr_idx_reg <= IDX_CTRL;
            rd_idx_reg <= IDX_CTRL;
            hreadyout_reg <= 1'b1;
        end else if (hce) begin
            wr_pend_reg <= accept && hwrite;
            rd_pend_reg <= accept && !hwrite;
            hreadyout_reg <= !(accept && !hwrite);
            if (accept && hwrite) begin
                wr_idx_reg <= haddr[IDX_LSB +: 6];
            end
            if (accept && !hwrite) begin
                rd_idx_reg <= haddr[IDX_LSB +: 6];
            end
        end
    end

    // Read mux, sampled in the wait cycle after any earlier write lands
    always_comb begin
        rd_word = 16'h0000;
        unique case (rd_idx_reg)
            IDX_STAT: rd_word[STAT_DONE] = done_reg; // RQ22
            IDX_PARTNER: rd_word = pa_reg;
            IDX_EXPAN: begin
                rd_word[EXP_PAR_FAULT] = exp_pf_reg;
                rd_word[EXP_PEER_NP] = exp_pnp_reg;
                rd_word[EXP_NP_ABLE] = 1'b1; // RQ11
                rd_word[EXP_PAGE_RX] = exp_pr_reg;
                rd_word[EXP_PEER_AN] = exp_ana_reg;
            end
            IDX_NP_TX: rd_word = np_tx_reg;
            IDX_NP_RX: rd_word = np_rx_reg; // RQ15
            IDX_GIG: rd_word = {gig_reg, 8'h00};
            default: rd_word = 16'h0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_reg <= RDATA_RST;
        end else if (hce && rd_now) begin
            hrdata_reg <= {16'h0000, rd_word};
        end
    end

    // Restart strobe clears itself after one cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            restart_reg <= 1'b0;
        end else if (hce) begin
            restart_reg <= wr_hit(IDX_CTRL) && hwdata[CTRL_RESTART]; // RQ21
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            done_reg <= 1'b0;
        end else if (hce) begin
            done_reg <= an_complete; // RQ22
        end
    end

    // Partner base page; a received base page wins over a software write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pa_reg <= PA_RST; // RQ1 RQ7
        end else if (hce) begin
            if (base_rx) begin
                pa_reg <= lcw_rx.link_code_word; // RQ3 RQ5 RQ6 RQ7
                pa_reg[PA_ACK] <= 1'b1; // RQ2
                pa_reg[PA_RSVD] <= 1'b0;
            end else begin
                if (next_rx) begin
                    pa_reg[PA_ACK] <= 1'b1; // RQ2
                end
                if (wr_hit(IDX_PARTNER)) begin
                    pa_reg[PA_ASYM] <= hwdata[PA_ASYM]; // RQ4
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            np_rx_reg <= NP_RX_RST;
        end else if (hce && next_rx) begin
            np_rx_reg <= lcw_rx.link_code_word; // RQ15
        end
    end

    // Expansion flags: an event in the clearing cycle keeps the flag set
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            exp_pf_reg <= 1'b0;
            exp_pr_reg <= 1'b0;
        end else if (hce) begin
            if (parallel_fault) begin
                exp_pf_reg <= 1'b1; // RQ8
            end else if (exp_clear) begin
                exp_pf_reg <= 1'b0; // RQ23
            end
            if (lcw_rx.valid) begin
                exp_pr_reg <= 1'b1; // RQ9
            end else if (exp_clear) begin
                exp_pr_reg <= 1'b0; // RQ23
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            exp_pnp_reg <= 1'b0;
            exp_ana_reg <= 1'b0;
        end else if (hce) begin
            exp_ana_reg <= partner_an_able; // RQ10
            if (base_rx) begin
                exp_pnp_reg <= lcw_rx.link_code_word[PA_NEXT_PAGE]; // RQ10
            end
        end
    end

    // Transmit next page; toggle flips after every word sent
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            np_tx_reg <= NP_TX_RST; // RQ14
        end else if (hce) begin
            if (wr_hit(IDX_NP_TX)) begin
                np_tx_reg[NP_MORE] <= hwdata[NP_MORE];
                np_tx_reg[NP_MSG] <= hwdata[NP_MSG];
                np_tx_reg[NP_COMPLY] <= hwdata[NP_COMPLY];
                np_tx_reg[10:0] <= hwdata[10:0]; // RQ14
            end
            if (tx_page_sent) begin
                np_tx_reg[NP_TOGGLE] <= !np_tx_reg[NP_TOGGLE]; // RQ13
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gig_reg <= gig_ctrl_s'(GIG_RST); // RQ17 RQ20
        end else if (hce && wr_hit(IDX_GIG)) begin
            gig_reg <= gig_ctrl_s'(hwdata[15:8]); // RQ19 RQ20
        end
    end

    // Reserved test codes fall back to normal transmission
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tm_reg <= TM_NORMAL;
            forced_reg <= 1'b0;
            master_reg <= 1'b0;
        end else if (hce) begin
            if (gig_reg.test_mode > 3'h4) begin
                tm_reg <= TM_NORMAL; // RQ17
            end else begin
                tm_reg <= test_mode_e'(gig_reg.test_mode); // RQ16
            end
            forced_reg <= gig_reg.ms_manual; // RQ18
            master_reg <= gig_reg.ms_manual && gig_reg.ms_master; // RQ18
        end
    end

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    AST_RESTART_PULSE: assert property ( // RQ21
        (hce && wr_hit(IDX_CTRL) && hwdata[CTRL_RESTART])
        |=> an_restart ##1 (!an_restart || !$past(hce)))
        else $error("restart strobe not a single pulse");

    AST_NP_ABLE: assert property ( // RQ11
        (hce && exp_clear) |=> hrdata[EXP_NP_ABLE])
        else $error("local next page able bit not set");

    AST_PAGE_RX: assert property ( // RQ9
        (hce && lcw_rx.valid) |=> exp_pr_reg)
        else $error("page received flag missed");

    AST_PF_HOLD: assert property ( // RQ8
        (hce && exp_pf_reg && !exp_clear) |=> exp_pf_reg)
        else $error("parallel fault flag dropped without read");

    AST_LH_CLEAR: assert property ( // RQ23
        (hce && exp_clear && !parallel_fault && !lcw_rx.valid)
        |=> !exp_pf_reg && !exp_pr_reg)
        else $error("latched flags not cleared by read");

    AST_TOGGLE: assert property ( // RQ13
        (hce && tx_page_sent && !wr_hit(IDX_NP_TX))
        |=> np_tx_word[NP_TOGGLE] != $past(np_tx_word[NP_TOGGLE]))
        else $error("toggle did not flip after send");

    AST_ACK_STICKY: assert property ( // RQ2
        (hce && lcw_rx.valid) |=> pa_reg[PA_ACK] ##1 pa_reg[PA_ACK])
        else $error("partner acknowledge not held");

    AST_ROLE: assert property ( // RQ18
        (hce && !gig_reg.ms_manual) |=> !role_master)
        else $error("role forced while manual disabled");

    AST_TEST_MODE: assert property ( // RQ16
        (hce && wr_hit(IDX_GIG) && hwdata[15:13] == 3'h2)
        ##1 hce |=> test_mode == TM_MASTER_JITTER)
        else $error("test mode not applied");

    AST_READ_WAIT: assert property ( // read takes one wait
        (hce && accept && !hwrite) |=> !hreadyout)
        else $error("read did not insert wait state");

    AST_BASE_NEXT_PAGE: assert property ( // RQ1
        (hce && base_rx) |=> pa_reg[PA_NEXT_PAGE]
            == $past(lcw_rx.link_code_word[PA_NEXT_PAGE]))
        else $error("partner next page bit not loaded");

    AST_BASE_FAULT: assert property ( // RQ3
        (hce && base_rx)
        |=> pa_reg[PA_FAULT] == $past(lcw_rx.link_code_word[PA_FAULT]))
        else $error("partner remote fault bit not loaded");

    AST_BASE_ABILITY: assert property ( // RQ5 RQ6
        (hce && base_rx)
        |=> pa_reg[9:5] == $past(lcw_rx.link_code_word[9:5]))
        else $error("partner ability bits not loaded");

    AST_BASE_SELECTOR: assert property ( // RQ7
        (hce && base_rx)
        |=> pa_reg[4:0] == $past(lcw_rx.link_code_word[4:0]))
        else $error("partner selector not loaded");

    AST_ASYM_WRITE: assert property ( // RQ4
        (hce && wr_hit(IDX_PARTNER) && !base_rx)
        |=> pa_reg[PA_ASYM] == $past(hwdata[PA_ASYM]))
        else $error("asymmetric pause bit not written");

    AST_SYM_PAUSE_RO: assert property ( // RQ4
        (hce && wr_hit(IDX_PARTNER) && !base_rx)
        |=> $stable(pa_reg[PA_ASYM-1:0]))
        else $error("read-only partner bits changed by write");

    AST_NP_RX_LOAD: assert property ( // RQ15
        (hce && next_rx) |=> np_rx_reg == $past(lcw_rx.link_code_word))
        else $error("received next page not loaded");

    AST_PEER_NP: assert property ( // RQ10
        (hce && base_rx)
        |=> exp_pnp_reg == $past(lcw_rx.link_code_word[PA_NEXT_PAGE]))
        else $error("partner next page able flag not loaded");

    AST_PEER_AN: assert property ( // RQ10
        (hce && hresetn) |=> exp_ana_reg == $past(partner_an_able))
        else $error("partner negotiation able flag not tracked");

    AST_PF_SET: assert property ( // RQ8
        (hce && parallel_fault) |=> exp_pf_reg)
        else $error("parallel fault flag missed");

    AST_CODE_WRITE: assert property ( // RQ14
        (hce && wr_hit(IDX_NP_TX))
        |=> np_tx_word[10:0] == $past(hwdata[10:0]))
        else $error("transmit code field not written");

    AST_GIG_WRITE: assert property ( // RQ19 RQ20
        (hce && wr_hit(IDX_GIG)) |=> gig_cfg == $past(hwdata[15:8]))
        else $error("gigabit control not written");

    AST_TM_RESERVED: assert property ( // RQ17
        (hce && gig_reg.test_mode > 3'h4) |=> test_mode == TM_NORMAL)
        else $error("reserved test code not mapped to normal");

    AST_DONE: assert property ( // RQ22
        (hce && hresetn) |=> done_reg == $past(an_complete))
        else $error("completion status not tracked");

    AST_FREEZE: assert property ( // RQ13
        !hce |=> $stable(np_tx_reg) && $stable(pa_reg)
            && $stable(exp_pr_reg))
        else $error("state changed while clock enable low");
endmodule : phy_an_regs

// ===== dv/an_link_peer.sv
// Link partner model: sends link code words and negotiation events.
// Assumes the caller is just past a rising hclk edge.
module an_link_peer
    import phy_an_pkg::*;
(
    input wire logic hclk,
    output lcw_rx_s lcw_rx,
    output logic tx_page_sent,
    output logic partner_an_able,
    output logic parallel_fault,
    output logic an_complete
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        lcw_rx = '0;
        tx_page_sent = 1'b0;
        partner_an_able = 1'b0;
        parallel_fault = 1'b0;
        an_complete = 1'b0;
    end

    // One-cycle word, then the lines show the inverse
    task automatic send(input logic base, input logic [15:0] w);
        @(posedge hclk);
        lcw_rx <= '{1'b1, base, w};
        @(posedge hclk);
        lcw_rx <= '{1'b0, 1'b0, ~w};
    endtask : send

    task automatic pulse(input int n, input logic fault);
        @(posedge hclk);
        if (fault) parallel_fault <= 1'b1;
        else tx_page_sent <= 1'b1;
        repeat (n) @(posedge hclk);
        parallel_fault <= 1'b0;
        tx_page_sent <= 1'b0;
    endtask : pulse

    task automatic level(input logic able, input logic done);
        partner_an_able <= able;
        an_complete <= done;
    endtask : level
endmodule : an_link_peer

// ===== dv/tb.sv
// Testbench for the auto-negotiation register bank.
// Assumes one AHB-Lite slave, hready tied to its hreadyout.
module tb
    import phy_an_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic w;
        logic [5:0] idx;
        logic [15:0] d;
        logic [15:0] e;
    } row_s;

    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hce = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, an_restart, role_forced, role_master;
    logic tx_page_sent, partner_an_able, parallel_fault, an_complete;
    logic [31:0] hrdata, q;
    logic [15:0] np_tx_word;
    lcw_rx_s lcw_rx;
    gig_ctrl_s gig_cfg;
    test_mode_e test_mode;
    int errors = 0;
    int checked = 0;
    int n;

    row_s rows [12] = '{
        '{1'b0, IDX_PARTNER, 16'h0000, 16'h0000},
        '{1'b0, IDX_EXPAN, 16'h0000, 16'h0004},
        '{1'b0, IDX_NP_TX, 16'h0000, 16'h2001},
        '{1'b0, IDX_NP_RX, 16'h0000, 16'h0000},
        '{1'b0, IDX_GIG, 16'h0000, 16'h0300},
        '{1'b1, IDX_GIG, 16'hFFFF, 16'h0000},
        '{1'b0, IDX_GIG, 16'h0000, 16'hFF00},
        '{1'b1, IDX_NP_TX, 16'hFFFF, 16'h0000},
        '{1'b1, IDX_NP_RX, 16'hFFFF, 16'h0000},
        '{1'b1, IDX_PARTNER, 16'hFFFF, 16'h0000},
        '{1'b1, 6'h3F, 16'hFFFF, 16'h0000},
        '{1'b0, 6'h3F, 16'h0000, 16'h0000}
    };

    always #20 hclk = ~hclk;

    phy_an_regs dut (
        .hclk, .hresetn, .hce, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp,
        .hrdata, .lcw_rx, .tx_page_sent, .partner_an_able, .parallel_fault,
        .an_complete, .an_restart, .np_tx_word, .gig_cfg, .test_mode,
        .role_forced, .role_master
    );

    an_link_peer peer (
        .hclk, .lcw_rx, .tx_page_sent, .partner_an_able, .parallel_fault,
        .an_complete
    );

    task automatic conclude;
        if (errors == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wait_ready;
        int k = 0;
        do begin
            @(posedge hclk);
            k++;
        end while (hreadyout !== 1'b1 && k < 64);
        if (hreadyout !== 1'b1) begin
            errors++;
            conclude();
        end
    endtask : wait_ready

    task automatic xfer(input logic w, input logic [5:0] idx,
                        input logic [15:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= {24'h0, idx, 2'b00};
        htrans <= 2'h2;
        hwrite <= w;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= {16'h0, d};
        wait_ready();
        r = hrdata;
    endtask : xfer

    task automatic rd(input logic [5:0] idx, input logic [15:0] e);
        xfer(1'b0, idx, 16'h0000, q);
        chk(q, {16'h0000, e});
    endtask : rd

    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        foreach (rows[i]) begin
            xfer(rows[i].w, rows[i].idx, rows[i].d, q);
            if (!rows[i].w) chk(q, {16'h0, rows[i].e});
        end
        rd(IDX_NP_TX, 16'hB7FF);
        rd(IDX_PARTNER, 16'h0800);
        chk({31'h0, hresp}, 32'h0);
        for (int i = 0; i < 8; i++) begin
            xfer(1'b1, IDX_GIG, {i[2:0], i[1], i[0], i[2], 10'h000}, q);
            repeat (2) @(posedge hclk);
            chk({29'h0, test_mode}, 32'(i > 4 ? 0 : i));
            chk({24'h0, gig_cfg}, {24'h0, i[2:0], i[1:0], i[2], 2'b00});
            chk({30'h0, role_forced, role_master},
                {30'h0, i[1], i[1] & i[0]});
        end
        peer.level(1'b1, 1'b0);
        peer.send(1'b1, 16'hBBE1);
        rd(IDX_PARTNER, 16'hEBE1);
        rd(IDX_EXPAN, 16'h000F);
        rd(IDX_EXPAN, 16'h000D);
        peer.pulse(1, 1'b1);
        rd(IDX_EXPAN, 16'h001D);
        rd(IDX_EXPAN, 16'h000D);
        peer.send(1'b1, 16'h0000);
        rd(IDX_PARTNER, 16'h4000);
        peer.send(1'b0, 16'h9ABC);
        rd(IDX_NP_RX, 16'h9ABC);
        rd(IDX_PARTNER, 16'h4000);
        peer.pulse(1, 1'b0);
        rd(IDX_NP_TX, 16'hBFFF);
        chk({16'h0, np_tx_word}, 32'h0000_BFFF);
        peer.pulse(2, 1'b0);
        rd(IDX_NP_TX, 16'hBFFF);
        hce <= 1'b0;
        peer.pulse(1, 1'b0);
        peer.send(1'b1, 16'hFFFF);
        hce <= 1'b1;
        rd(IDX_NP_TX, 16'hBFFF);
        rd(IDX_PARTNER, 16'h4000);
        xfer(1'b1, IDX_CTRL, 16'h0200, q);
        n = 0;
        repeat (4) begin
            @(posedge hclk);
            if (an_restart === 1'b1) n++;
        end
        chk(32'(n), 32'h1);
        rd(IDX_CTRL, 16'h0000);
        peer.level(1'b1, 1'b1);
        rd(IDX_STAT, 16'h0020);
        peer.level(1'b1, 1'b0);
        rd(IDX_STAT, 16'h0000);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        rd(IDX_GIG, 16'h0300);
        rd(IDX_PARTNER, 16'h0000);
        rd(IDX_NP_TX, 16'h2001);
        conclude();
    end
endmodule : tb
